// ===== src/ssep_pkg.sv
// constants shared by the security sector erase and program block
`default_nettype none
package ssep_pkg;
  // ***************************************************************
  // clock and timing
  // ***************************************************************
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned SECTOR_ERASE_TIME_US = 300_000;
  localparam int unsigned PAGE_PROG_TIME_US = 700;
  localparam int unsigned ERASE_CYCLES = SECTOR_ERASE_TIME_US * CLK_PER_US;
  localparam int unsigned PROG_CYCLES = PAGE_PROG_TIME_US * CLK_PER_US;
  localparam int TIMER_W = 24;
  // ***************************************************************
  // instruction layout
  // ***************************************************************
  localparam logic [7:0] OP_ERASE = 8'h44;
  localparam logic [7:0] OP_PROG = 8'h42;
  localparam logic [7:0] ADDR_TOP_ZERO = 8'h00;
  localparam logic [5:0] ADDR_MID_ZERO = 6'h00;
  localparam logic [2:0] BYTES_ERASE = 3'h4;
  localparam logic [2:0] BYTES_PROG = 3'h5;
  localparam int ADDR_W = 10;
  localparam int PAGE_W = 8;
  localparam int PAGE_BYTES = 256;
  localparam int SECTOR_BYTES = 1024;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic RST_WEL = 1'h0;
  localparam logic RST_LOCK = 1'h0;
  localparam logic RST_WIP = 1'h0;
  typedef enum logic [1:0] {
    SSEP_IDLE = 2'b00,
    SSEP_WAIT = 2'b01,
    SSEP_FILL = 2'b10
  } ssep_state_e;
endpackage
`default_nettype wire

// ===== src/ssep_sector_mem.sv
// storage array of the erasable security sector
`default_nettype none
module ssep_sector_mem (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_we,
  input wire logic i_erase,
  input wire logic [ssep_pkg::ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [ssep_pkg::ADDR_W-1:0] i_rd_addr,
  output logic [7:0] o_rd_data
);
  // ***************************************************************
  // array
  // ***************************************************************
  logic [7:0] mem [ssep_pkg::SECTOR_BYTES];

  // programming only clears bits, like real cells
  always_ff @(posedge i_ref_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_erase ? ssep_pkg::ERASED_BYTE : (mem[i_addr] & i_wdata); // RULE1
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data <= 8'h00;
    end else begin
      o_rd_data <= mem[i_rd_addr];
    end
  end
endmodule
`default_nettype wire

// ===== src/ssep_top.sv
// security sector erase and program sequencer
// Function
// RULE1: one 1024-byte sector, separate from main array
// RULE2: erase needs write enable latch set
// RULE3: erase is 44h, address top bits zero
// RULE4: chip select rise off byte boundary discards erase
// RULE5: erase runs self-timed after chip select rise
// RULE6: in-progress flag high during cycle, then low
// RULE7: erase completion clears write enable latch
// RULE8: lock bit set ignores erase
// RULE9: lock bit never returns to zero; the code clears it to RST_LOCK on i_rst_n
// RULE10: program is 42h, page and byte address
// RULE11: program takes one to 256 data bytes
// RULE12: program needs write enable latch set
// RULE13: chip select stays low through all data
// RULE14: lock bit set ignores program
// RULE15: only accepted in single-line serial mode
// RULE16: program runs busy, then clears flag and latch
`default_nettype none
module ssep_top #(
  parameter int unsigned ERASE_CYCLES_P = ssep_pkg::ERASE_CYCLES,
  parameter int unsigned PROG_CYCLES_P = ssep_pkg::PROG_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_serial_data_in,
  input wire logic i_quad_mode,
  input wire logic i_wel_set,
  input wire logic i_lock_set,
  input wire logic [ssep_pkg::ADDR_W-1:0] i_rd_addr,
  output logic o_write_in_progress,
  output logic o_write_enable_latch,
  output logic o_security_lock_bit,
  output logic [7:0] o_rd_data
);
  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  logic [2:0] pin_raw;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic sclk_d;
  logic cs_d;
  assign pin_raw = {i_cs_n, i_sclk, i_serial_data_in};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          sync1[g] <= 1'b1;
          sync2[g] <= 1'b1;
        end else begin
          sync1[g] <= pin_raw[g];
          sync2[g] <= sync1[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sclk_d <= 1'b1;
      cs_d <= 1'b1;
    end else begin
      sclk_d <= sync2[1];
      cs_d <= sync2[2];
    end
  end

  logic cs_n_s;
  logic di_s;
  logic sclk_rise;
  logic cs_fall;
  logic cs_rise;
  assign cs_n_s = sync2[2];
  assign di_s = sync2[0];
  assign sclk_rise = sync2[1] & ~sclk_d;
  assign cs_fall = ~cs_n_s & cs_d;
  assign cs_rise = cs_n_s & ~cs_d;

  // ***************************************************************
  // state
  // ***************************************************************
  ssep_pkg::ssep_state_e state, next_state;
  logic [6:0] shift, next_shift;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [2:0] byte_cnt, next_byte_cnt;
  logic [7:0] opcode, next_opcode;
  logic [23:0] addr, next_addr;
  logic [ssep_pkg::PAGE_W-1:0] ptr, next_ptr;
  logic [ssep_pkg::PAGE_BYTES-1:0] valid, next_valid;
  logic frame_ok, next_frame_ok;
  logic is_erase, next_is_erase;
  logic [ssep_pkg::TIMER_W-1:0] timer, next_timer;
  logic [ssep_pkg::ADDR_W-1:0] fill_idx, next_fill_idx;
  logic write_in_progress, next_wip;
  logic write_enable_latch, next_wel;
  logic lock, next_lock;
  logic [7:0] page_data [ssep_pkg::PAGE_BYTES];

  logic [7:0] byte_val;
  logic byte_done;
  logic data_wr;
  logic addr_ok;
  logic may_write;
  logic erase_ok;
  logic prog_ok;
  logic fill_last;
  logic mem_we;
  logic [ssep_pkg::ADDR_W-1:0] mem_addr;

  assign byte_val = {shift, di_s};
  assign byte_done = ~cs_n_s & sclk_rise & (bit_cnt == 3'h7);
  // first data byte ends at count 4, later ones at the saturated count
  assign data_wr = byte_done & frame_ok & (byte_cnt >= ssep_pkg::BYTES_ERASE) &
                   (opcode == ssep_pkg::OP_PROG);
  assign addr_ok = (addr[23:16] == ssep_pkg::ADDR_TOP_ZERO) &&
                   (addr[15:10] == ssep_pkg::ADDR_MID_ZERO); // RULE3 RULE10
  // gates common to both instructions
  assign may_write = frame_ok & write_enable_latch & ~lock & ~i_quad_mode & addr_ok &
                     (bit_cnt == 3'h0); // RULE2 RULE12 RULE8 RULE14 RULE15
  assign erase_ok = may_write & (opcode == ssep_pkg::OP_ERASE) &
                    (byte_cnt == ssep_pkg::BYTES_ERASE); // RULE4
  // byte_cnt saturates after the first data byte, so one byte is the minimum
  assign prog_ok = may_write & (opcode == ssep_pkg::OP_PROG) &
                   (byte_cnt == ssep_pkg::BYTES_PROG); // RULE11 RULE13
  assign fill_last = is_erase ?
                     (fill_idx == ssep_pkg::ADDR_W'(ssep_pkg::SECTOR_BYTES - 1)) :
                     (fill_idx[ssep_pkg::PAGE_W-1:0] ==
                      ssep_pkg::PAGE_W'(ssep_pkg::PAGE_BYTES - 1));
  assign mem_we = (state == ssep_pkg::SSEP_FILL) &
                  (is_erase | valid[fill_idx[ssep_pkg::PAGE_W-1:0]]);
  assign mem_addr = is_erase ? fill_idx : {addr[9:8], fill_idx[ssep_pkg::PAGE_W-1:0]};

  // ***************************************************************
  // next values
  // ***************************************************************
  always_comb begin
    next_state = state;
    next_shift = shift;
    next_bit_cnt = bit_cnt;
    next_byte_cnt = byte_cnt;
    next_opcode = opcode;
    next_addr = addr;
    next_ptr = ptr;
    next_valid = valid;
    next_frame_ok = frame_ok;
    next_is_erase = is_erase;
    next_timer = timer;
    next_fill_idx = fill_idx;
    next_wip = write_in_progress;
    next_wel = write_enable_latch;
    next_lock = lock | i_lock_set; // RULE9
    if (cs_fall) begin
      next_bit_cnt = 3'h0;
      next_byte_cnt = 3'h0;
      // busy device only answers status reads elsewhere
      next_frame_ok = (state == ssep_pkg::SSEP_IDLE);
      next_valid = '0;
    end else if (~cs_n_s && sclk_rise) begin
      next_shift = byte_val[6:0];
      next_bit_cnt = bit_cnt + 3'h1;
      if (byte_done) begin
        if (byte_cnt != ssep_pkg::BYTES_PROG) begin
          next_byte_cnt = byte_cnt + 3'h1;
        end
        if (byte_cnt == 3'h0) begin
          next_opcode = byte_val;
        end else if (byte_cnt < ssep_pkg::BYTES_ERASE) begin
          next_addr = {addr[15:0], byte_val};
        end
        if (byte_cnt == 3'h3) begin
          next_ptr = byte_val;
        end
        if (data_wr) begin
          next_valid[ptr] = 1'b1;
          // beyond 256 bytes the pointer wraps within the page
          next_ptr = ptr + 8'h01;
        end
      end
    end
    unique case (state)
      ssep_pkg::SSEP_IDLE: begin
        if (cs_rise && (erase_ok || prog_ok)) begin
          next_state = ssep_pkg::SSEP_WAIT; // RULE5 RULE16
          next_is_erase = erase_ok;
          next_timer = erase_ok ? ssep_pkg::TIMER_W'(ERASE_CYCLES_P - 1) :
                                  ssep_pkg::TIMER_W'(PROG_CYCLES_P - 1);
          next_fill_idx = '0;
          next_wip = 1'b1; // RULE6
        end
      end
      ssep_pkg::SSEP_WAIT: begin
        if (timer == '0) begin
          next_state = ssep_pkg::SSEP_FILL;
        end else begin
          next_timer = timer - 1'b1;
        end
      end
      ssep_pkg::SSEP_FILL: begin
        next_fill_idx = fill_idx + 1'b1;
        if (fill_last) begin
          next_state = ssep_pkg::SSEP_IDLE;
          next_wip = 1'b0; // RULE6
          next_wel = 1'b0; // RULE7 RULE16
        end
      end
      default: begin
        next_state = ssep_pkg::SSEP_IDLE;
        next_wip = 1'b0;
      end
    endcase
    // a set arriving with the completion clear wins
    if (i_wel_set) begin
      next_wel = 1'b1;
    end
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ssep_pkg::SSEP_IDLE;
      shift <= '0;
      bit_cnt <= '0;
      byte_cnt <= '0;
      opcode <= '0;
      addr <= '0;
      ptr <= '0;
      valid <= '0;
      frame_ok <= 1'b0;
      is_erase <= 1'b0;
      timer <= '0;
      fill_idx <= '0;
      write_in_progress <= ssep_pkg::RST_WIP;
      write_enable_latch <= ssep_pkg::RST_WEL;
      lock <= ssep_pkg::RST_LOCK;
    end else begin
      state <= next_state;
      shift <= next_shift;
      bit_cnt <= next_bit_cnt;
      byte_cnt <= next_byte_cnt;
      opcode <= next_opcode;
      addr <= next_addr;
      ptr <= next_ptr;
      valid <= next_valid;
      frame_ok <= next_frame_ok;
      is_erase <= next_is_erase;
      timer <= next_timer;
      fill_idx <= next_fill_idx;
      write_in_progress <= next_wip;
      write_enable_latch <= next_wel;
      lock <= next_lock;
    end
  end

  // page data needs no reset: valid bits guard every entry
  always_ff @(posedge i_ref_clk) begin
    if (data_wr) begin
      page_data[ptr] <= byte_val; // RULE11
    end
  end

  assign o_write_in_progress = write_in_progress;
  assign o_write_enable_latch = write_enable_latch;
  assign o_security_lock_bit = lock;

  // ***************************************************************
  // sector storage
  // ***************************************************************
  ssep_sector_mem u_mem (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_we(mem_we),
    .i_erase(is_erase),
    .i_addr(mem_addr),
    .i_wdata(page_data[fill_idx[ssep_pkg::PAGE_W-1:0]]),
    .i_rd_addr(i_rd_addr),
    .o_rd_data(o_rd_data)
  );
endmodule
`default_nettype wire

// ===== tb/ssep_monitor.sv
// port checker for the security sector sequencer
`default_nettype none
module ssep_monitor #(
  parameter int unsigned ERASE_CYCLES_P = 20,
  parameter int unsigned PROG_CYCLES_P = 10
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_serial_data_in,
  input wire logic i_quad_mode,
  input wire logic i_wel_set,
  input wire logic i_lock_set,
  input wire logic [ssep_pkg::ADDR_W-1:0] i_rd_addr,
  input wire logic o_write_in_progress,
  input wire logic o_write_enable_latch,
  input wire logic o_security_lock_bit,
  input wire logic [7:0] o_rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [23:0] busy_cnt;
  logic [23:0] next_busy_cnt;
  always_comb begin
    next_busy_cnt = o_write_in_progress ? busy_cnt + 24'h1 : 24'h0;
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_cnt <= 24'h0;
    end else begin
      busy_cnt <= next_busy_cnt;
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_start;
    $rose(o_write_in_progress);
  endsequence
  sequence s_done;
    $fell(o_write_in_progress) && !$past(i_wel_set);
  endsequence
  chk_start_wel: assert property (s_start |-> o_write_enable_latch)
    else $error("busy began without write enable");
  chk_start_cs: assert property (s_start |-> $past(i_cs_n, 2))
    else $error("busy began before chip select rose");
  chk_start_quad: assert property (s_start |-> !$past(i_quad_mode, 2))
    else $error("busy began in four-line mode");
  chk_start_lock: assert property (s_start |-> !$past(o_security_lock_bit))
    else $error("busy began while locked");
  chk_lock_sticky: assert property (o_security_lock_bit |=> o_security_lock_bit)
    else $error("lock bit cleared");
  chk_lock_set: assert property (i_lock_set |=> o_security_lock_bit)
    else $error("lock bit not set");
  chk_wel_set: assert property (i_wel_set |=> o_write_enable_latch)
    else $error("write enable not set");
  chk_done_wel: assert property (s_done |-> !o_write_enable_latch)
    else $error("write enable kept after cycle");
  chk_busy_len: assert property ($fell(o_write_in_progress) |->
    (busy_cnt == ERASE_CYCLES_P + ssep_pkg::SECTOR_BYTES) ||
    (busy_cnt == PROG_CYCLES_P + ssep_pkg::PAGE_BYTES))
    else $error("busy span wrong");
endmodule
bind ssep_top ssep_monitor #(.ERASE_CYCLES_P(ERASE_CYCLES_P), .PROG_CYCLES_P(PROG_CYCLES_P))
  ssep_monitor_inst (.i_ref_clk, .i_rst_n, .i_cs_n, .i_sclk, .i_serial_data_in, .i_quad_mode,
  .i_wel_set, .i_lock_set, .i_rd_addr, .o_write_in_progress, .o_write_enable_latch,
  .o_security_lock_bit, .o_rd_data);
`default_nettype wire

// ===== tb/ssep_host.sv
// serial host model that frames instructions
`default_nettype none
module ssep_host (
  input wire logic i_ref_clk,
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_sdi
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_sdi = 1'b0;
  end
  // five clocks a phase: the sampler needs three
  task automatic send(input logic [47:0] f, input int n);
    o_cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      o_sdi = f[47-i];
      repeat (5) @(posedge i_ref_clk);
      #1 o_sclk = 1'b1;
      repeat (5) @(posedge i_ref_clk);
      #1 o_sclk = 1'b0;
    end
    repeat (5) @(posedge i_ref_clk);
    #1 o_cs_n = 1'b1;
    o_sdi = ~o_sdi;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the security sector sequencer
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst_n, cs_n, sclk, sdi, quad, wel_set, lock_set, write_in_progress, write_enable_latch, lock;
  logic [9:0] rd_addr;
  logic [7:0] rd_data;
  int fail_count = 0;
  int checked = 0;
  always #50 ref_clk = ~ref_clk;
  ssep_host ssep_host_inst (.i_ref_clk(ref_clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(sdi));
  ssep_top #(.ERASE_CYCLES_P(20), .PROG_CYCLES_P(10)) ssep_top_inst (.i_ref_clk(ref_clk),
    .i_rst_n(rst_n), .i_cs_n(cs_n), .i_sclk(sclk), .i_serial_data_in(sdi), .i_quad_mode(quad),
    .i_wel_set(wel_set), .i_lock_set(lock_set), .i_rd_addr(rd_addr),
    .o_write_in_progress(write_in_progress), .o_write_enable_latch(write_enable_latch), .o_security_lock_bit(lock),
    .o_rd_data(rd_data));
  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // one instruction; judges whether a busy cycle ran
  task automatic op(input logic [47:0] f, input int n, input logic w, input logic busy);
    logic seen;
    int k;
    seen = 1'b0;
    if (w) begin
      wel_set = 1'b1;
      tick();
      wel_set = 1'b0;
    end
    ssep_host_inst.send(f, n);
    for (k = 0; k < 12; k++) begin
      tick();
      if (write_in_progress === 1'b1) seen = 1'b1;
    end
    k = 0;
    while (write_in_progress !== 1'b0 && k < 3000) begin
      tick();
      k++;
    end
    chk("busy", seen, busy);
    if (busy) chk("wel", write_enable_latch, 8'h00);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    rd_addr = a;
    tick();
    chk("mem", rd_data, exp);
  endtask
  task automatic t_erase;
    op(48'h440003FF0000, 32, 1'b1, 1'b1);
    rd(10'h000, 8'hFF);
    rd(10'h3FF, 8'hFF);
  endtask
  task automatic t_prog;
    op(48'h42000110AABB, 48, 1'b1, 1'b1);
    rd(10'h110, 8'hAA);
    rd(10'h111, 8'hBB);
    rd(10'h112, 8'hFF);
    op(48'h420003FF1234, 48, 1'b1, 1'b1);
    rd(10'h3FF, 8'h12);
    rd(10'h300, 8'h34);
    op(48'h420001100F00, 40, 1'b1, 1'b1);
    rd(10'h110, 8'h0A);
  endtask
  task automatic t_refuse;
    op(48'h440000000000, 32, 1'b0, 1'b0);
    op(48'h42000110FF00, 40, 1'b0, 1'b0);
    op(48'h440100000000, 32, 1'b1, 1'b0);
    op(48'h440004000000, 32, 1'b1, 1'b0);
    op(48'h430000000000, 32, 1'b1, 1'b0);
    op(48'h440000000000, 40, 1'b1, 1'b0);
    op(48'h440000000000, 31, 1'b1, 1'b0);
    op(48'h420001100000, 32, 1'b1, 1'b0);
    op(48'h420001100000, 44, 1'b1, 1'b0);
    quad = 1'b1;
    op(48'h440000000000, 32, 1'b1, 1'b0);
    quad = 1'b0;
    chk("wel kept", write_enable_latch, 8'h01);
  endtask
  // a frame that opens while busy stays refused even if it closes when idle
  task automatic t_busy;
    logic seen;
    seen = 1'b0;
    wel_set = 1'b1;
    tick();
    wel_set = 1'b0;
    ssep_host_inst.send(48'h420001100F00, 40);
    repeat (5) tick();
    chk("prog busy", write_in_progress, 8'h01);
    fork
      ssep_host_inst.send(48'h440000000000, 32);
      begin
        while (write_in_progress !== 1'b0) tick();
        wel_set = 1'b1;
        tick();
        wel_set = 1'b0;
      end
    join
    repeat (12) begin
      tick();
      if (write_in_progress === 1'b1) seen = 1'b1;
    end
    chk("busy gate", seen, 8'h00);
    rd(10'h110, 8'h0A);
  endtask
  task automatic t_lock;
    lock_set = 1'b1;
    tick();
    lock_set = 1'b0;
    op(48'h440000000000, 32, 1'b1, 1'b0);
    op(48'h420001100000, 40, 1'b1, 1'b0);
    rd(10'h110, 8'h0A);
    chk("lock", lock, 8'h01);
  endtask
  initial begin
    rst_n = 1'b0;
    quad = 1'b0;
    wel_set = 1'b0;
    lock_set = 1'b0;
    rd_addr = 10'h000;
    repeat (2) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    repeat (4) tick();
    t_erase();
    t_prog();
    t_refuse();
    t_busy();
    t_lock();
    final_report();
  end
  initial begin
    repeat (40000) @(posedge ref_clk);
    fail_count++;
    final_report();
  end
endmodule
`default_nettype wire
